// ===== src/tmbc_pkg.sv
// shared constants and types of the track mode and brake control block
// assumes one 250 MHz core clock and 8-bit configuration registers
package tmbc_pkg;

  // ****************************************************************
  // track and packet encodings
  // ****************************************************************
  typedef enum logic [1:0] {TRK_NONE, TRK_DIGITAL, TRK_DC, TRK_AC}
    tmbc_track_t;
  typedef enum logic [1:0] {FMT_PRIMARY, FMT_TRINARY, FMT_BUS, FMT_AUTO}
    tmbc_fmt_t;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [4:0] REG_ACCEL       = 5'h00;
  localparam logic [4:0] REG_DECEL       = 5'h01;
  localparam logic [4:0] REG_BRAKE_CFG   = 5'h02;
  localparam logic [4:0] REG_MODE_CFG    = 5'h03;
  localparam logic [4:0] REG_ANALOG_CFG  = 5'h04;
  localparam logic [4:0] REG_EXIT_DELAY  = 5'h05;
  localparam logic [4:0] REG_SLOW_SPEED  = 5'h06;
  localparam logic [4:0] REG_ASYM_THRESH = 5'h07;
  localparam logic [4:0] REG_SHUTTLE     = 5'h08;
  localparam logic [4:0] REG_LIMIT0      = 5'h09;
  localparam logic [4:0] REG_PROFILE     = 5'h0e;
  localparam logic [4:0] REG_DISTANCE    = 5'h0f;
  localparam logic [4:0] REG_CTRL        = 5'h10;
  localparam logic [4:0] REG_STATUS      = 5'h11;
  localparam logic [4:0] REG_SPEED       = 5'h12;
  localparam int         CFG_REGS        = 16;
  localparam int         LIMIT_REGS      = 5;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int BRK_ASYM_LEFT_BIT  = 1;
  localparam int BRK_ASYM_RIGHT_BIT = 2;
  localparam int BRK_DC_BIT         = 3;
  localparam int BRK_MODULE_BIT     = 4;
  localparam int MODE_ANALOG_BIT    = 2;
  localparam int CTRL_DIR_KEEP_BIT  = 0;

  // ****************************************************************
  // values after reset, index 0 in the low byte
  // ****************************************************************
  localparam logic [15:0][7:0] CFG_RESET = {
    8'h00, 8'h00, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h00,
    8'h0c, 8'hff, 8'h00, 8'h03, 8'h04, 8'h00, 8'h02, 8'h02};
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] RAMP_MAX   = 8'h3f;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS     = 4;
  localparam int TICK_TIME_NS      = 1000000;
  localparam int TICK_CYCLES       = TICK_TIME_NS / CLK_PERIOD_NS;
  localparam int FMT_HOLD_TIME_MS  = 4000;
  localparam int SEC_TIME_MS       = 1000;
  localparam int EXIT_UNIT_MS      = 10;
  localparam int CD_SHIFT          = 8;

endpackage : tmbc_pkg

// ===== src/tmbc_core.sv
// track mode change and brake sector control of a locomotive decoder
// assumes a track front end on the same clock that classifies the track
// signal and decodes packets; track_power comes from a pin
`timescale 1ns/1ps

// Operation
// - digital into DC with matching polarity: run on at analogue speed
// - DC polarity mismatch: stop when DC brake bit set, else reverse out
// - entering AC from digital keeps direction, speed follows analogue voltage
// - entering digital with matching direction continues at commanded speed
// - retention set, mismatch: keep direction until direction change command
// - retention clear and mismatch: stop, reverse and head back
// - packets of both main digital formats are acted on, except under bus lock or format hold
// - after bus format, other formats accepted only after track power loss
// - leaving auto-registration, drop primary and trinary packets about 4 s, hold motion
// - analogue disabled: hold speed and direction, no commands until digital
// - any brake stops with deceleration, then restarts with acceleration
// - DC brake and module bits both set: DC voltage is a stop
// - diode brake sector of the bus format stops the locomotive
// - asymmetric signal stops; right-stronger bit 2, left-stronger bit 1
// - slow-approach section limits speed to its register, 255 full, 0 stop
// - asymmetry threshold register, default 12
// - nonzero shuttle wait: stop, wait, reverse, restart; zero disables
// - with bit 2, stepped speed-limit commands use the five limit registers
// - brake left only after no detection for the exit delay
// - nonzero distance selects constant-distance braking, zero time-based
// - constant distance only in brake sectors; throttle zero uses decel time
// - profile zero: linear deceleration at once, stop after set distance
// - profile nonzero: cruise, then constant effort, timed to stop correctly
// - acceleration and deceleration times 0 to 63, per speed step
module tmbc_core
  import tmbc_pkg::*;
#(
  parameter int unsigned TICK_CYCLES_P  = tmbc_pkg::TICK_CYCLES,
  parameter int unsigned FMT_HOLD_MS_P  = tmbc_pkg::FMT_HOLD_TIME_MS
) (
  // clock, reset, enable
  input  wire logic                 clock,
  input  wire logic                 reset_n,
  input  wire logic                 ce,
  // register port
  input  wire logic [4:0]           reg_addr,
  input  wire logic [7:0]           reg_wdata,
  input  wire logic                 reg_write,
  input  wire logic                 reg_read,
  output      logic [7:0]           reg_rdata,
  // track classification
  input  wire tmbc_pkg::tmbc_track_t track_mode,
  input  wire logic                 track_power,
  input  wire logic                 dc_polarity_fwd,
  input  wire logic [7:0]           analog_speed,
  // decoded packets
  input  wire logic                 pkt_valid,
  input  wire tmbc_pkg::tmbc_fmt_t  pkt_format,
  input  wire logic [7:0]           pkt_speed,
  input  wire logic                 pkt_dir,
  // brake sector detection
  input  wire logic [7:0]           asym_right_level,
  input  wire logic [7:0]           asym_left_level,
  input  wire logic                 slow_approach_det,
  input  wire logic                 diode_brake_det,
  input  wire logic                 limit_valid,
  input  wire logic [2:0]           limit_index,
  // motor command
  output      logic [7:0]           motor_speed,
  output      logic                 motor_dir,
  output      logic                 braking
);
  import tmbc_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  localparam int TW = $clog2(TICK_CYCLES_P + 1);

  typedef enum logic [1:0] {ST_RUN, ST_REV_STOP, ST_BRAKE, ST_SHUTTLE}
    tmbc_phase_t;

  typedef struct packed {
    logic [15:0][7:0] cfg;
    logic [7:0]       ctrl;
    logic [7:0]       rdata;
    logic             pwr_s1;
    logic             pwr_s2;
    logic [TW-1:0]    tick_cnt;
    tmbc_track_t      prev_track;
    tmbc_phase_t      st;
    logic [7:0]       speed;
    logic             dir;
    logic             rev_dir;
    logic [7:0]       step_cnt;
    logic [7:0]       cmd_speed;
    logic             cmd_dir;
    logic             sx_lock;
    logic             last_auto;
    logic [11:0]      fmt_hold;
    logic             ignore_dir;
    logic             dir_pending;
    logic             analog_hold;
    logic [7:0]       held_speed;
    logic             dc_brk;
    logic             brk_hold;
    logic [11:0]      exit_cnt;
    logic [17:0]      wait_cnt;
    logic             shuttle_mask;
    logic [7:0]       cd_v0;
    logic             cd_cruise;
    logic [24:0]      cd_acc;
  } tmbc_regs_t;

  tmbc_regs_t s;
  tmbc_regs_t next_s;

  function automatic logic [7:0] tmbc_min(input logic [7:0] a,
                                          input logic [7:0] b);
    tmbc_min = (a < b) ? a : b;
  endfunction : tmbc_min

  // values above the documented range behave as the range end
  function automatic logic [7:0] tmbc_ramp(input logic [7:0] v);
    tmbc_ramp = tmbc_min(v, RAMP_MAX);
  endfunction : tmbc_ramp

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin : next_logic
    logic        tick;
    logic        pkt_ok;
    logic        analog_off;
    logic        abc_raw;
    logic        abc_req;
    logic        module_brk;
    logic        brake_req;
    logic        want_dir;
    logic        follow_dir;
    logic [8:0]  diff_r;
    logic [8:0]  diff_l;
    logic [7:0]  brk_cfg;
    logic [7:0]  tgt;
    logic [7:0]  accel_t;
    logic [7:0]  decel_t;
    logic [2:0]  lim_i;
    logic [15:0] v0_sq;
    logic [16:0] two_d;
    logic [25:0] need;
    tick       = 1'b0;
    pkt_ok     = 1'b0;
    analog_off = 1'b0;
    abc_raw    = 1'b0;
    abc_req    = 1'b0;
    module_brk = 1'b0;
    brake_req  = 1'b0;
    want_dir   = 1'b0;
    follow_dir = 1'b0;
    diff_r     = 9'h000;
    diff_l     = 9'h000;
    brk_cfg    = 8'h00;
    tgt        = 8'h00;
    accel_t    = 8'h00;
    decel_t    = 8'h00;
    lim_i      = 3'h0;
    v0_sq      = 16'h0000;
    two_d      = 17'h00000;
    need       = 26'h0000000;
    next_s     = s;

    // register port
    if (reg_write) begin
      if (reg_addr < 5'(CFG_REGS)) begin
        next_s.cfg[reg_addr[3:0]] = reg_wdata;
      end else if (reg_addr == REG_CTRL) begin
        next_s.ctrl = reg_wdata;
      end
    end
    next_s.rdata = 8'h00;
    if (reg_read) begin
      if (reg_addr < 5'(CFG_REGS)) begin
        next_s.rdata = s.cfg[reg_addr[3:0]];
      end else if (reg_addr == REG_CTRL) begin
        next_s.rdata = s.ctrl;
      end else if (reg_addr == REG_STATUS) begin
        next_s.rdata = {2'b00, s.sx_lock, (s.fmt_hold != 12'h000),
                        s.ignore_dir, (s.st == ST_SHUTTLE), s.brk_hold,
                        s.dir};
      end else if (reg_addr == REG_SPEED) begin
        next_s.rdata = s.speed;
      end
    end

    // millisecond tick; the pin is synchronised before use
    next_s.pwr_s1 = track_power;
    next_s.pwr_s2 = s.pwr_s1;
    next_s.tick_cnt = s.tick_cnt + TW'(1);
    if (s.tick_cnt == TW'(TICK_CYCLES_P - 1)) begin
      next_s.tick_cnt = '0;
      tick = 1'b1;
    end

    brk_cfg    = s.cfg[REG_BRAKE_CFG[3:0]];
    accel_t    = tmbc_ramp(s.cfg[REG_ACCEL[3:0]]);
    decel_t    = tmbc_ramp(s.cfg[REG_DECEL[3:0]]);
    analog_off = !s.cfg[REG_MODE_CFG[3:0]][MODE_ANALOG_BIT] ||
                 (s.cfg[REG_ANALOG_CFG[3:0]] == 8'h00);

    // ****************************************************************
    // digital format acceptance
    // ****************************************************************
    if (!s.pwr_s2) begin
      next_s.sx_lock = 1'b0;
    end
    if (tick && s.fmt_hold != 12'h000) begin
      next_s.fmt_hold = s.fmt_hold - 12'h001;
    end
    if (pkt_valid && track_mode == TRK_DIGITAL) begin
      case (pkt_format)
        FMT_BUS: begin
          pkt_ok = 1'b1;
          next_s.sx_lock = 1'b1;
        end
        FMT_AUTO: begin
          pkt_ok = !s.sx_lock;
          next_s.last_auto = !s.sx_lock;
        end
        default: begin
          // both main formats decoded side by side
          if (s.sx_lock) begin
            pkt_ok = 1'b0;
          end else if (s.last_auto) begin
            next_s.last_auto = 1'b0;
            next_s.fmt_hold = 12'(FMT_HOLD_MS_P);
          end else begin
            pkt_ok = (s.fmt_hold == 12'h000);
          end
        end
      endcase
    end

    if (pkt_ok) begin
      if (s.dir_pending) begin
        next_s.dir_pending = 1'b0;
        if (pkt_dir == s.dir) begin
          next_s.ignore_dir = 1'b0;
        end else if (s.ctrl[CTRL_DIR_KEEP_BIT]) begin
          next_s.ignore_dir = 1'b1;
        end else begin
          next_s.ignore_dir = 1'b1;
          next_s.st = ST_REV_STOP;
          next_s.rev_dir = !s.dir;
        end
      end else if (s.ignore_dir && pkt_dir != s.cmd_dir) begin
        next_s.ignore_dir = 1'b0;
      end
      next_s.cmd_speed = pkt_speed;
      next_s.cmd_dir = pkt_dir;
    end

    // ****************************************************************
    // track mode changes
    // ****************************************************************
    next_s.prev_track = track_mode;
    if (track_mode != s.prev_track) begin
      next_s.dc_brk = 1'b0;
      if (track_mode == TRK_DIGITAL) begin
        next_s.analog_hold = 1'b0;
        next_s.dir_pending = (s.prev_track == TRK_DC) ||
                             (s.prev_track == TRK_AC);
      end else if (track_mode == TRK_DC || track_mode == TRK_AC) begin
        if (analog_off) begin
          next_s.analog_hold = 1'b1;
          next_s.held_speed = s.speed;
        end else if (track_mode == TRK_DC && s.prev_track == TRK_DIGITAL &&
                     dc_polarity_fwd != s.dir) begin
          if (brk_cfg[BRK_DC_BIT]) begin
            next_s.dc_brk = 1'b1;
          end else begin
            next_s.st = ST_REV_STOP;
            next_s.rev_dir = dc_polarity_fwd;
          end
        end
      end
    end

    // ****************************************************************
    // brake detection and exit filter
    // ****************************************************************
    diff_r = {1'b0, asym_right_level} - {1'b0, asym_left_level};
    diff_l = {1'b0, asym_left_level} - {1'b0, asym_right_level};
    abc_raw = (brk_cfg[BRK_ASYM_RIGHT_BIT] && !diff_r[8] &&
               diff_r[7:0] >= s.cfg[REG_ASYM_THRESH[3:0]]) ||
              (brk_cfg[BRK_ASYM_LEFT_BIT] && !diff_l[8] &&
               diff_l[7:0] >= s.cfg[REG_ASYM_THRESH[3:0]]);
    if (!abc_raw) begin
      next_s.shuttle_mask = 1'b0;
    end
    abc_req = abc_raw && !s.shuttle_mask;
    // module voltage looks like plain DC, so both bits force a stop
    module_brk = track_mode == TRK_DC && brk_cfg[BRK_DC_BIT] &&
                 brk_cfg[BRK_MODULE_BIT];
    brake_req = s.dc_brk || module_brk || diode_brake_det ||
                abc_req;
    if (brake_req) begin
      next_s.brk_hold = 1'b1;
      next_s.exit_cnt = 12'h000;
    end else if (s.brk_hold) begin
      // dropouts shorter than the delay restart the count
      if (s.exit_cnt >= 12'(s.cfg[REG_EXIT_DELAY[3:0]] * EXIT_UNIT_MS)) begin
        next_s.brk_hold = 1'b0;
      end else if (tick) begin
        next_s.exit_cnt = s.exit_cnt + 12'h001;
      end
    end

    // ****************************************************************
    // target speed and direction
    // ****************************************************************
    case (track_mode)
      TRK_DIGITAL: begin
        tgt = s.cmd_speed;
        // entry cycle must already see the pending compare
        want_dir = next_s.cmd_dir;
        follow_dir = !next_s.ignore_dir && !next_s.dir_pending;
      end
      TRK_DC: begin
        tgt = s.analog_hold ? s.held_speed : analog_speed;
        want_dir = dc_polarity_fwd;
        follow_dir = !next_s.analog_hold && !next_s.dc_brk;
      end
      TRK_AC: begin
        tgt = s.analog_hold ? s.held_speed : analog_speed;
        want_dir = s.dir;
      end
      default: begin
        tgt = s.speed;
        want_dir = s.dir;
      end
    endcase
    if (s.fmt_hold != 12'h000) begin
      tgt = s.speed;
      follow_dir = 1'b0;
    end
    if (slow_approach_det) begin
      tgt = tmbc_min(tgt, s.cfg[REG_SLOW_SPEED[3:0]]);
    end
    if (brk_cfg[BRK_ASYM_RIGHT_BIT] && limit_valid) begin
      lim_i = (limit_index > 3'(LIMIT_REGS - 1)) ? 3'(LIMIT_REGS - 1)
                                                  : limit_index;
      tgt = tmbc_min(tgt, s.cfg[4'(REG_LIMIT0) + 4'(lim_i)]);
    end

    // ****************************************************************
    // phase control
    // ****************************************************************
    case (s.st)
      ST_RUN, ST_REV_STOP: begin
        if (s.brk_hold) begin
          next_s.st = ST_BRAKE;
          tgt = 8'h00;
          next_s.cd_v0 = s.speed;
          next_s.cd_acc = '0;
          next_s.step_cnt = 8'h00;
          next_s.cd_cruise = (s.cfg[REG_PROFILE[3:0]] != 8'h00);
        end else if (s.st == ST_REV_STOP || next_s.st == ST_REV_STOP) begin
          tgt = 8'h00;
          if (s.st == ST_REV_STOP && s.speed == 8'h00) begin
            next_s.dir = s.rev_dir;
            next_s.st = ST_RUN;
          end
        end else if (follow_dir && want_dir != s.dir) begin
          if (s.speed == 8'h00) begin
            next_s.dir = want_dir;
          end else begin
            next_s.st = ST_REV_STOP;
            next_s.rev_dir = want_dir;
            tgt = 8'h00;
          end
        end
      end
      ST_BRAKE: begin
        tgt = 8'h00;
        if (s.speed == 8'h00 && abc_req &&
            s.cfg[REG_SHUTTLE[3:0]] != 8'h00) begin
          next_s.st = ST_SHUTTLE;
          next_s.wait_cnt = '0;
        end else if (!s.brk_hold) begin
          next_s.st = ST_RUN;
        end
      end
      ST_SHUTTLE: begin
        tgt = 8'h00;
        if (s.wait_cnt >= 18'(s.cfg[REG_SHUTTLE[3:0]] * SEC_TIME_MS)) begin
          // brake sits on one rail only, so the reversed run leaves it
          next_s.dir = !s.dir;
          next_s.shuttle_mask = 1'b1;
          next_s.st = ST_RUN;
        end else if (tick) begin
          next_s.wait_cnt = s.wait_cnt + 18'h00001;
        end
      end
      default: begin
        next_s.st = ST_RUN;
      end
    endcase

    // ****************************************************************
    // speed ramp, advanced once per millisecond
    // ****************************************************************
    v0_sq = 16'(s.cd_v0) * 16'(s.cd_v0);
    two_d = 17'(s.cfg[REG_DISTANCE[3:0]]) << (CD_SHIFT + 1);
    if (tick) begin
      if (s.speed < tgt) begin
        if (accel_t == 8'h00) begin
          next_s.speed = tgt;
        end else if (s.step_cnt + 8'h01 >= accel_t) begin
          next_s.speed = s.speed + 8'h01;
          next_s.step_cnt = 8'h00;
        end else begin
          next_s.step_cnt = s.step_cnt + 8'h01;
        end
      end else if (s.speed > tgt && s.st == ST_BRAKE &&
                   s.cfg[REG_DISTANCE[3:0]] != 8'h00) begin
        if (s.cfg[REG_PROFILE[3:0]] == 8'h00) begin
          // one step per tick at most: very short distances run long
          if (25'(s.cd_acc) + 25'(v0_sq) >= 25'(two_d)) begin
            next_s.speed = s.speed - 8'h01;
            next_s.cd_acc = s.cd_acc + 25'(v0_sq) - 25'(two_d);
          end else begin
            next_s.cd_acc = s.cd_acc + 25'(v0_sq);
          end
        end else if (s.cd_cruise) begin
          // travelled plus braking distance reaches the set distance
          need = 26'(s.cd_acc) +
                 26'(24'(v0_sq) * 24'(s.cfg[REG_PROFILE[3:0]]) >> 1);
          next_s.cd_acc = s.cd_acc + 25'(s.cd_v0);
          if (need >= 26'(two_d >> 1)) begin
            next_s.cd_cruise = 1'b0;
          end
        end else if (s.step_cnt + 8'h01 >= s.cfg[REG_PROFILE[3:0]]) begin
          next_s.speed = s.speed - 8'h01;
          next_s.step_cnt = 8'h00;
        end else begin
          next_s.step_cnt = s.step_cnt + 8'h01;
        end
      end else if (s.speed > tgt) begin
        if (decel_t == 8'h00) begin
          next_s.speed = tgt;
        end else if (s.step_cnt + 8'h01 >= decel_t) begin
          next_s.speed = s.speed - 8'h01;
          next_s.step_cnt = 8'h00;
        end else begin
          next_s.step_cnt = s.step_cnt + 8'h01;
        end
      end
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s <= '{cfg: CFG_RESET, ctrl: CTRL_RESET, prev_track: TRK_NONE,
             st: ST_RUN, default: '0};
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign reg_rdata   = s.rdata;
  assign motor_speed = s.speed;
  assign motor_dir   = s.dir;
  assign braking     = s.brk_hold;

endmodule : tmbc_core

// ===== tb/tmbc_track_model.sv
// command station and booster model on the decoder's track side
// assumes the bench calls its tasks from one process
`timescale 1ns/1ps
module tmbc_track_model (
  // clock
  input  wire logic           clock,
  // track signal
  output tmbc_pkg::tmbc_track_t track_mode,
  output logic                track_power,
  output logic                dc_polarity_fwd,
  output logic [7:0]          analog_speed,
  // packets
  output logic                pkt_valid,
  output tmbc_pkg::tmbc_fmt_t pkt_format,
  output logic [7:0]          pkt_speed,
  output logic                pkt_dir
);
  import tmbc_pkg::*;
  initial begin
    track_mode = TRK_DIGITAL;
    track_power = 1'b1;
    dc_polarity_fwd = 1'b0;
    analog_speed = 8'h00;
    pkt_valid = 1'b0;
    pkt_format = FMT_PRIMARY;
    pkt_speed = 8'h00;
    pkt_dir = 1'b0;
  end
  // speed and direction flip once released so stale data never looks valid
  task send(input tmbc_fmt_t f, input logic [7:0] s, input logic d);
    @(posedge clock);
    pkt_valid <= 1'b1;
    pkt_format <= f;
    pkt_speed <= s;
    pkt_dir <= d;
    @(posedge clock);
    pkt_valid <= 1'b0;
    pkt_speed <= ~s;
    pkt_dir <= ~d;
  endtask : send
  task cut(input int n);
    @(posedge clock);
    track_power <= 1'b0;
    repeat (n) @(posedge clock);
    track_power <= 1'b1;
  endtask : cut
  task mode(input tmbc_track_t m, input logic p, input logic [7:0] v);
    @(posedge clock);
    track_mode <= m;
    dc_polarity_fwd <= p;
    analog_speed <= v;
  endtask : mode
endmodule : tmbc_track_model

// ===== tb/tmbc_core_sva.sv
// assertions on read data, brake state and speed ramp
// assumes a 10-cycle tick and ramp times above zero
`timescale 1ns/1ps
module tmbc_core_sva (
  input wire logic       clock,
  input wire logic       reset_n,
  input wire logic       ce,
  input wire logic [4:0] reg_addr,
  input wire logic       reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic       diode_brake_det,
  input wire logic [7:0] motor_speed,
  input wire logic       braking
);
  import tmbc_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  sequence s_brake_on; braking && motor_speed != 8'h00; endsequence
  sequence s_slowed; !braking || $changed(motor_speed); endsequence
  AST_RDATA_IDLE: assert property (
    ce && !reg_read |=> reg_rdata == 8'h00)
    else $error("read data not idle");
  AST_UNMAPPED: assert property (
    ce && reg_read && reg_addr > REG_SPEED |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_SPEED_STEP: assert property (
    $changed(motor_speed) |->
      (motor_speed - $past(motor_speed)) == 8'h01 ||
      ($past(motor_speed) - motor_speed) == 8'h01)
    else $error("speed jumped");
  AST_SPEED_PACE: assert property (
    $changed(motor_speed) |=> $stable(motor_speed))
    else $error("speed stepped twice");
  AST_BRAKE_SET: assert property (ce && diode_brake_det |=> braking)
    else $error("diode sector not braking");
  AST_BRAKE_HOLD: assert property (
    $fell(braking) |-> !$past(diode_brake_det))
    else $error("brake left under detection");
  AST_BRAKE_NOINC: assert property (
    $past(braking, 2) && braking |-> motor_speed <= $past(motor_speed))
    else $error("speed rose while braking");
  AST_BRAKE_RAMP: assert property (s_brake_on |-> ##[1:700] s_slowed)
    else $error("brake ramp stalled");
endmodule : tmbc_core_sva
bind tmbc_core tmbc_core_sva u_sva (.clock, .reset_n, .ce, .reg_addr,
  .reg_read, .reg_rdata, .diode_brake_det, .motor_speed, .braking);

// ===== tb/tmbc_core_tb_top.sv
// self-checking bench of the track mode and brake control block
// assumes a 10-cycle ms tick and a 5 ms format hold
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin fails++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module tmbc_core_tb_top;
  import tmbc_pkg::*;
  logic        clock = 1'b0;
  logic        reset_n = 1'b0;
  logic        reg_write = 1'b0;
  logic        reg_read = 1'b0;
  logic [4:0]  reg_addr = 5'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic [7:0]  asym_r = 8'h00;
  logic [7:0]  asym_l = 8'h00;
  logic        diode = 1'b0;
  logic        ce = 1'b1;
  logic        slow = 1'b0;
  logic        lim_v = 1'b0;
  logic [2:0]  lim_i = 3'h0;
  logic [7:0]  reg_rdata, motor_speed, pkt_speed, analog_speed, rv;
  logic        motor_dir, braking, track_power, pol_fwd, pkt_valid, pkt_dir;
  tmbc_track_t track_mode;
  tmbc_fmt_t   pkt_format;
  int          fails = 0;
  int          n_tests = 0;
  int          exp_spd, base;
  always #2 clock = ~clock;
  tmbc_track_model u_trk (.clock, .track_mode, .track_power,
    .dc_polarity_fwd(pol_fwd), .analog_speed, .pkt_valid, .pkt_format,
    .pkt_speed, .pkt_dir);
  tmbc_core #(.TICK_CYCLES_P(10), .FMT_HOLD_MS_P(5)) u_dut (.clock,
    .reset_n, .ce, .reg_addr, .reg_wdata, .reg_write, .reg_read,
    .reg_rdata, .track_mode, .track_power, .dc_polarity_fwd(pol_fwd),
    .analog_speed, .pkt_valid, .pkt_format, .pkt_speed, .pkt_dir,
    .asym_right_level(asym_r), .asym_left_level(asym_l),
    .slow_approach_det(slow), .diode_brake_det(diode), .limit_valid(lim_v),
    .limit_index(lim_i), .motor_speed, .motor_dir, .braking);
  task stop_test;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  task wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask : wr
  task rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  // waits for the expected speed and brake state, then realigns to the edge
  task settle(input int e, input logic b);
    int i;
    #1;
    for (i = 0; i < 20000 && (motor_speed !== e[7:0] || braking !== b); i++)
      @(posedge clock) #1;
    if (i == 20000) begin
      fails++;
      stop_test();
    end
    `CHK("speed", e[7:0], motor_speed)
    @(posedge clock);
  endtask : settle
  initial begin
    void'($urandom(81));
    repeat (8) @(posedge clock);
    reset_n <= 1'b1;
    for (int a = 0; a < CFG_REGS; a++) begin
      rd(a[4:0], rv);
      `CHK("cfg", CFG_RESET[a], rv)
    end
    rd(5'h1f, rv);
    `CHK("unmapped", 8'h00, rv)
    exp_spd = 1 + $urandom % 30;
    u_trk.send(FMT_PRIMARY, exp_spd[7:0], 1'b0);
    settle(exp_spd, 1'b0);
    u_trk.send(FMT_TRINARY, 8'h05, 1'b0);
    settle(5, 1'b0);
    wr(REG_EXIT_DELAY, 8'h01);
    diode <= 1'b1;
    settle(0, 1'b1);
    // short dropouts must not end the brake
    repeat (3) begin
      diode <= 1'b0;
      repeat (40) @(posedge clock);
      diode <= 1'b1;
      @(posedge clock);
    end
    diode <= 1'b0;
    repeat (85) @(posedge clock);
    #1 `CHK("exit_hold", 1'b1, braking)
    settle(5, 1'b0);
    for (int k = 1; k <= 2; k++) begin
      wr(REG_BRAKE_CFG, 8'h01 << k);
      base = 40 + $urandom % 100;
      asym_r <= base[7:0] + ((k == 1) ? 8'h0c : 8'h00);
      asym_l <= base[7:0] + ((k == 2) ? 8'h0c : 8'h00);
      repeat (50) @(posedge clock);
      #1 `CHK("asym_side", 1'b0, braking)
      @(posedge clock);
      asym_r <= asym_l;
      asym_l <= asym_r;
      settle(0, 1'b1);
      asym_l <= asym_r;
      settle(5, 1'b0);
    end
    // index above four must act as the last limit
    wr(REG_LIMIT0 + 5'h04, 8'h02);
    lim_i <= 3'(4 + $urandom % 4);
    lim_v <= 1'b1;
    settle(2, 1'b0);
    wr(REG_SLOW_SPEED, 8'h01);
    slow <= 1'b1;
    settle(1, 1'b0);
    lim_v <= 1'b0;
    slow <= 1'b0;
    settle(5, 1'b0);
    ce <= 1'b0;
    u_trk.send(FMT_PRIMARY, 8'h09, 1'b0);
    ce <= 1'b1;
    repeat (100) @(posedge clock);
    #1 `CHK("ce_freeze", 8'h05, motor_speed)
    u_trk.send(FMT_BUS, 8'h07, 1'b0);
    settle(7, 1'b0);
    u_trk.send(FMT_PRIMARY, 8'h02, 1'b0);
    repeat (100) @(posedge clock);
    #1 `CHK("bus_lock", 8'h07, motor_speed)
    u_trk.cut(4);
    u_trk.send(FMT_PRIMARY, 8'h02, 1'b0);
    settle(2, 1'b0);
    wr(REG_BRAKE_CFG, 8'h08);
    u_trk.mode(TRK_DC, 1'b0, 8'h09);
    settle(9, 1'b0);
    u_trk.mode(TRK_DIGITAL, 1'b0, 8'h00);
    u_trk.send(FMT_PRIMARY, 8'h04, 1'b0);
    settle(4, 1'b0);
    u_trk.mode(TRK_DC, 1'b1, 8'h09);
    settle(0, 1'b1);
    #1 `CHK("dir_keep", 1'b0, motor_dir)
    stop_test();
  end
endmodule : tmbc_core_tb_top
